// ---- scd_ctl.sv ----
// controller end: encodes user requests onto the command pins legally
`timescale 1ns/1ns
module scd_ctl
    import scd_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic req_vld,
    input wire scd_cmd_t req_cmd,
    input wire logic [BA_W-1:0] req_ba,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic req_cke,
    input wire logic usr_reset,
    input wire logic usr_odt,
    output logic req_ack,
    output logic req_rej,
    scd_link_if.ctl link
);
    typedef struct packed {
        logic reset_n;
        logic cke;
        logic cs_n;
        logic [2:0] rcw;
        logic odt;
        logic [BA_W-1:0] ba;
        logic [ADDR_W-1:0] addr;
        logic [NBANK-1:0] open;
        logic [CNT_W-1:0] hcnt;
        logic ack;
        logic rej;
    } scd_ctl_st_t;

    scd_ctl_st_t st_r;
    scd_ctl_st_t st_nxt;
    logic ok;
    logic nopdes;
    logic [2:0] enc;

    always_comb
    begin
        case (req_cmd)
            CMD_MRS: enc = RCW_MRS;
            CMD_REF: enc = RCW_REF;
            CMD_PRE: enc = RCW_PRE;
            CMD_ACT: enc = RCW_ACT;
            CMD_WR: enc = RCW_WR;
            CMD_RD: enc = RCW_RD;
            CMD_ZQ: enc = RCW_ZQ;
            default: enc = RCW_NOP;
        endcase
    end

    assign nopdes = (req_cmd == CMD_NOP) || (req_cmd == CMD_DES);

    // only legal pairs of cke history and command are let through
    always_comb
    begin
        ok = 1'b1;
        if ((req_cke != st_r.cke) && (st_r.hcnt != '0))
        begin
            ok = 1'b0;
        end
        else if (!st_r.cke)
        begin
            ok = nopdes;
        end
        else if (!req_cke)
        begin
            ok = nopdes || ((req_cmd == CMD_REF) && (st_r.open == '0));
        end
        else if (req_cmd == CMD_ACT)
        begin
            ok = ~st_r.open[req_ba];
        end
        else if ((req_cmd == CMD_RD) || (req_cmd == CMD_WR))
        begin
            ok = st_r.open[req_ba];
        end
    end

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.reset_n = ~usr_reset;
        st_nxt.odt = usr_odt;
        st_nxt.ack = 1'b0;
        st_nxt.rej = 1'b0;
        st_nxt.cs_n = 1'b1;
        st_nxt.rcw = RCW_NOP;
        if (st_r.hcnt != '0)
        begin
            st_nxt.hcnt = st_r.hcnt - CNT_W'(1);
        end
        if (usr_reset)
        begin
            st_nxt.open = '0;
            st_nxt.cke = 1'b0;
            // a reset that drops cke still owes the minimum cke hold
            if (st_r.cke)
            begin
                st_nxt.hcnt = CNT_W'(CKE_CYC);
            end
        end
        else if (req_vld && ok)
        begin
            st_nxt.ack = 1'b1;
            st_nxt.cke = req_cke;
            if (req_cke != st_r.cke)
            begin
                st_nxt.hcnt = CNT_W'(CKE_CYC);
            end
            st_nxt.cs_n = (req_cmd == CMD_DES);
            st_nxt.rcw = enc;
            st_nxt.ba = req_ba;
            st_nxt.addr = req_addr;
            case (req_cmd)
                CMD_ACT: st_nxt.open[req_ba] = 1'b1;
                CMD_PRE:
                begin
                    if (req_addr[A10])
                    begin
                        st_nxt.open = '0;
                    end
                    else
                    begin
                        st_nxt.open[req_ba] = 1'b0;
                    end
                end
                CMD_RD, CMD_WR:
                begin
                    if (req_addr[A10])
                    begin
                        st_nxt.open[req_ba] = 1'b0;
                    end
                end
                default: st_nxt.open = st_r.open;
            endcase
        end
        else if (req_vld)
        begin
            st_nxt.rej = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign link.reset_n = st_r.reset_n;
    assign link.cke = st_r.cke;
    assign link.cs_n = st_r.cs_n;
    assign link.ras_n = st_r.rcw[2];
    assign link.cas_n = st_r.rcw[1];
    assign link.we_n = st_r.rcw[0];
    assign link.odt = st_r.odt;
    assign link.ba = st_r.ba;
    assign link.addr = st_r.addr;
    assign req_ack = st_r.ack;
    assign req_rej = st_r.rej;
endmodule // scd_ctl

// ---- scd_dev.sv ----
// sdram end: command decode, bank/burst tracking and cke power states
`timescale 1ns/1ns
module scd_dev
    import scd_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    scd_link_if.dev link,
    output logic cmd_vld,
    output scd_cmd_t cmd,
    output logic [BA_W-1:0] cmd_ba,
    output logic [ADDR_W-1:0] cmd_addr,
    output logic cmd_ap,
    output logic cmd_chop,
    output logic zq_long,
    output logic [MR_NUM-1:0][ADDR_W-1:0] mode_regs,
    output scd_pst_t pstate,
    output logic [NBANK-1:0] bank_open,
    output logic burst_busy,
    output logic dev_idle
);
    typedef struct packed {
        logic cke_q;
        scd_pst_t pst;
        logic [NBANK-1:0] open;
        logic [CNT_W-1:0] bcnt;
        logic [CNT_W-1:0] pcnt;
        logic [CNT_W-1:0] rcnt;
        logic [CNT_W-1:0] xcnt;
        logic [MR_NUM-1:0][ADDR_W-1:0] mr;
        logic cmd_vld;
        scd_cmd_t cmd;
        logic [BA_W-1:0] ba;
        logic [ADDR_W-1:0] addr;
        logic ap;
        logic chop;
        logic zq_long;
        logic busy;
        logic idle;
    } scd_dev_st_t;

    scd_dev_st_t st_r;
    scd_dev_st_t st_nxt;
    logic arst_n;
    logic sel;
    logic nopdes;
    logic idle_now;
    logic [2:0] rcw;
    logic [1:0] bl_mode;
    logic chop;
    logic [CNT_W-1:0] blen;

    // link reset acts without the clock, as does the local reset
    assign arst_n = rstn & link.reset_n;

    // odt is deliberately not looked at anywhere in the decode
    assign sel = ~link.cs_n;
    assign rcw = {link.ras_n, link.cas_n, link.we_n};
    assign nopdes = ~sel | (rcw == RCW_NOP);
    assign bl_mode = st_r.mr[0][MR0_BL_LSB +: 2];
    assign chop = (bl_mode == BL_OTF) ? ~link.addr[A12] : (bl_mode == BL_FIX4);
    assign blen = chop ? CNT_W'(BC4_CYC) : CNT_W'(BL8_CYC);
    assign idle_now = (st_r.open == '0) && (st_r.bcnt == '0) && (st_r.pcnt == '0)
        && (st_r.rcnt == '0) && (st_r.xcnt == '0) && st_r.cke_q;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.cmd_vld = 1'b0;
        st_nxt.cke_q = link.cke;
        if (st_r.bcnt != '0)
        begin
            st_nxt.bcnt = st_r.bcnt - CNT_W'(1);
        end
        if (st_r.pcnt != '0)
        begin
            st_nxt.pcnt = st_r.pcnt - CNT_W'(1);
        end
        if (st_r.rcnt != '0)
        begin
            st_nxt.rcnt = st_r.rcnt - CNT_W'(1);
        end
        if (st_r.xcnt != '0)
        begin
            st_nxt.xcnt = st_r.xcnt - CNT_W'(1);
        end
        case (st_r.pst)
            PS_NORM:
            begin
                if (st_r.cke_q && link.cke && sel && (rcw != RCW_NOP))
                begin
                    st_nxt.cmd_vld = 1'b1;
                    st_nxt.ba = link.ba;
                    st_nxt.addr = link.addr;
                    st_nxt.ap = 1'b0;
                    st_nxt.chop = 1'b0;
                    case (rcw)
                        RCW_MRS:
                        begin
                            st_nxt.cmd = CMD_MRS;
                            st_nxt.mr[link.ba[1:0]] = link.addr;
                        end
                        RCW_REF:
                        begin
                            st_nxt.cmd = CMD_REF;
                            st_nxt.rcnt = CNT_W'(REF_CYC);
                        end
                        RCW_PRE:
                        begin
                            st_nxt.cmd = CMD_PRE;
                            st_nxt.ap = link.addr[A10];
                            if (link.addr[A10])
                            begin
                                st_nxt.open = '0;
                            end
                            else
                            begin
                                st_nxt.open[link.ba] = 1'b0;
                            end
                            st_nxt.pcnt = CNT_W'(PRE_CYC);
                        end
                        RCW_ACT:
                        begin
                            st_nxt.cmd = CMD_ACT;
                            st_nxt.open[link.ba] = 1'b1;
                        end
                        RCW_WR, RCW_RD:
                        begin
                            st_nxt.cmd = (rcw == RCW_WR) ? CMD_WR : CMD_RD;
                            st_nxt.chop = chop;
                            st_nxt.ap = link.addr[A10];
                            // a new burst queues behind the running one, never cutting it
                            st_nxt.bcnt = st_nxt.bcnt + blen;
                            if (link.addr[A10])
                            begin
                                st_nxt.open[link.ba] = 1'b0;
                                st_nxt.pcnt = st_nxt.bcnt + CNT_W'(PRE_CYC);
                            end
                        end
                        default:
                        begin
                            st_nxt.cmd = CMD_ZQ;
                            st_nxt.zq_long = link.addr[A10];
                        end
                    endcase
                end
                else if (st_r.cke_q && !link.cke)
                begin
                    if (nopdes)
                    begin
                        if (st_r.open != '0)
                        begin
                            st_nxt.pst = PS_PDA;
                        end
                        else if ((st_r.bcnt != '0) || (st_r.pcnt != '0))
                        begin
                            st_nxt.pst = PS_PD;
                        end
                        else
                        begin
                            st_nxt.pst = PS_PDP;
                        end
                    end
                    else if ((rcw == RCW_REF) && idle_now)
                    begin
                        st_nxt.pst = PS_SR;
                    end
                end
            end
            PS_PDA, PS_PDP, PS_PD:
            begin
                // nothing refreshes here; cke low keeps the state regardless of inputs
                if (link.cke && nopdes)
                begin
                    st_nxt.pst = PS_NORM;
                    st_nxt.xcnt = CNT_W'(XP_CYC);
                end
            end
            PS_SR:
            begin
                // leaves on cke alone, the command inputs are not decoded
                if (link.cke)
                begin
                    st_nxt.pst = PS_NORM;
                    st_nxt.xcnt = CNT_W'(XS_CYC);
                end
            end
            default:
            begin
                st_nxt.pst = PS_NORM;
            end
        endcase
        st_nxt.busy = (st_nxt.bcnt != '0);
        st_nxt.idle = (st_nxt.open == '0) && (st_nxt.bcnt == '0) && (st_nxt.pcnt == '0)
            && (st_nxt.rcnt == '0) && (st_nxt.xcnt == '0) && st_nxt.cke_q
            && (st_nxt.pst == PS_NORM);
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign cmd_vld = st_r.cmd_vld;
    assign cmd = st_r.cmd;
    assign cmd_ba = st_r.ba;
    assign cmd_addr = st_r.addr;
    assign cmd_ap = st_r.ap;
    assign cmd_chop = st_r.chop;
    assign zq_long = st_r.zq_long;
    assign mode_regs = st_r.mr;
    assign pstate = st_r.pst;
    assign bank_open = st_r.open;
    assign burst_busy = st_r.busy;
    assign dev_idle = st_r.idle;
endmodule // scd_dev

// ---- scd_link_assertions.sv ----
// concurrent checks on the command link pins between controller and sdram
`timescale 1ns/1ns
module scd_link_assertions
    import scd_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic reset_n,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic odt,
    input wire logic [BA_W-1:0] ba,
    input wire logic [ADDR_W-1:0] addr
);
    logic [2:0] code;
    logic vld;
    logic cke_r;
    logic [NBANK-1:0] open_r;
    assign code = {ras_n, cas_n, we_n};
    assign vld = cke & cke_r & ~cs_n;
    // banks left open by the commands seen on the wire
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cke_r <= 1'b0;
            open_r <= '0;
        end
        else
        begin
            cke_r <= cke;
            if (!reset_n)
                open_r <= '0;
            else if (vld && code == RCW_ACT)
                open_r[ba] <= 1'b1;
            else if (vld && code == RCW_PRE && addr[A10])
                open_r <= '0;
            else if (vld && (code == RCW_PRE || (code[2:1] == 2'b10 && addr[A10])))
                open_r[ba] <= 1'b0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_fall;
        cke ##1 !cke;
    endsequence
    sequence s_rise;
        !cke ##1 cke;
    endsequence
    property p_cke_hold;
        $changed(cke) |=> $stable(cke) [*2];
    endproperty
    property p_pde_code;
        s_fall |-> cs_n || code == RCW_NOP || code == RCW_REF;
    endproperty
    property p_exit_code;
        s_rise |-> cs_n || code == RCW_NOP;
    endproperty
    property p_low_code;
        // commands mean nothing while cke stays low with the sdram out of reset
        !$past(cke) && !cke && reset_n |-> cs_n || code == RCW_NOP;
    endproperty
    property p_act_closed;
        vld && code == RCW_ACT |-> !open_r[ba];
    endproperty
    property p_rdwr_open;
        vld && code[2:1] == 2'b10 |-> open_r[ba];
    endproperty
    property p_sre_idle;
        s_fall ##0 (!cs_n && code == RCW_REF) |-> open_r == '0;
    endproperty
    property p_reset_cke;
        !reset_n ##1 !reset_n |-> !cke;
    endproperty
    a_cke_hold: assert property (p_cke_hold) else $error("cke held too briefly");
    a_pde_code: assert property (p_pde_code) else $error("bad code at cke fall");
    a_exit_code: assert property (p_exit_code) else $error("bad code at cke rise");
    a_low_code: assert property (p_low_code) else $error("command while cke low");
    a_act_closed: assert property (p_act_closed) else $error("activate to open bank");
    a_rdwr_open: assert property (p_rdwr_open) else $error("access to closed bank");
    a_sre_idle: assert property (p_sre_idle) else $error("self refresh not idle");
    a_reset_cke: assert property (p_reset_cke) else $error("cke high in reset");
endmodule // scd_link_assertions

// ---- scd_link_if.sv ----
// command, address, cke and reset pins between controller and sdram
`timescale 1ns/1ns
interface scd_link_if
    import scd_pkg::*;
();
    logic reset_n;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic odt;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;

    modport dev (
        input reset_n,
        input cke,
        input cs_n,
        input ras_n,
        input cas_n,
        input we_n,
        input odt,
        input ba,
        input addr
    );

    modport ctl (
        output reset_n,
        output cke,
        output cs_n,
        output ras_n,
        output cas_n,
        output we_n,
        output odt,
        output ba,
        output addr
    );
endinterface

// ---- scd_pkg.sv ----
// shared constants and types for the sdram command link
// Notes on behaviour
// - commands sampled only on rising clock edge
// - cs/ras/cas/we decode to nine commands
// - bank from ba, row/column from address
// - otf burst chop via a12 when enabled
// - started bursts always run to completion
// - mrs loads one of four mode registers
// - device reset is asynchronous active low
// - controller keeps device reset high normally
// - odt never affects command decode
// - nop starts nothing, running work continues
// - deselect ignores inputs, running work continues
// - deselect and nop behave identically
// - no refresh performed while in power-down
// - self refresh exit needs no command decode
// - cke transitions enter/exit power-down, self refresh
// - power-down kind depends on device activity
// - idle means closed, quiet, cke high, timed
// - controller holds cke minimum edges after change
// - cke low-low keeps state, ignores commands
// - controller issues only legal state/command pairs
// - zq with a10 high is long calibration
// - controller rejects activate to a bank already open
package scd_pkg;
    localparam int BA_W = 3;
    localparam int ADDR_W = 16;
    localparam int NBANK = 8;
    localparam int MR_NUM = 4;
    localparam int A10 = 10;
    localparam int A12 = 12;
    localparam int CNT_W = 6;
    localparam logic [2:0] RCW_MRS = 3'h0;
    localparam logic [2:0] RCW_REF = 3'h1;
    localparam logic [2:0] RCW_PRE = 3'h2;
    localparam logic [2:0] RCW_ACT = 3'h3;
    localparam logic [2:0] RCW_WR = 3'h4;
    localparam logic [2:0] RCW_RD = 3'h5;
    localparam logic [2:0] RCW_ZQ = 3'h6;
    localparam logic [2:0] RCW_NOP = 3'h7;
    localparam int MR0_BL_LSB = 0;
    localparam logic [1:0] BL_FIX8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_FIX4 = 2'h2;
    localparam logic [15:0] MR_RST = 16'h0000;
    localparam int BL8_CYC = 4;
    localparam int BC4_CYC = 2;
    localparam int CLK_NS = 100;
    localparam int PRE_NS = 200;
    localparam int REF_NS = 1600;
    localparam int XP_NS = 300;
    localparam int XS_NS = 800;
    localparam int CKE_NS = 300;
    localparam int PRE_CYC = (PRE_NS + CLK_NS - 1) / CLK_NS;
    localparam int REF_CYC = (REF_NS + CLK_NS - 1) / CLK_NS;
    localparam int XP_CYC = (XP_NS + CLK_NS - 1) / CLK_NS;
    localparam int XS_CYC = (XS_NS + CLK_NS - 1) / CLK_NS;
    localparam int CKE_CYC = (CKE_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [3:0] {
        CMD_MRS = 4'h0,
        CMD_REF = 4'h1,
        CMD_PRE = 4'h2,
        CMD_ACT = 4'h3,
        CMD_WR = 4'h4,
        CMD_RD = 4'h5,
        CMD_ZQ = 4'h6,
        CMD_NOP = 4'h7,
        CMD_DES = 4'h8
    } scd_cmd_t;

    typedef enum logic [2:0] {
        PS_NORM = 3'h0,
        PS_PDA = 3'h1,
        PS_PDP = 3'h3,
        PS_PD = 3'h2,
        PS_SR = 3'h6
    } scd_pst_t;
endpackage

// ---- sdram_command_cke_decoder_tb.sv ----
// bench: controller end drives the sdram end across the link
`timescale 1ns/1ns
module sdram_command_cke_decoder_tb
    import scd_pkg::*;
();
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic req_vld = 1'b0;
    scd_cmd_t req_cmd = CMD_NOP;
    logic [BA_W-1:0] req_ba = '0;
    logic [ADDR_W-1:0] req_addr = '0;
    logic req_cke = 1'b0;
    logic usr_reset = 1'b0;
    logic usr_odt = 1'b0;
    logic req_ack, req_rej, cmd_vld, cmd_ap, cmd_chop, zq_long, burst_busy, dev_idle, ak, rj;
    scd_cmd_t cmd;
    logic [BA_W-1:0] cmd_ba;
    logic [ADDR_W-1:0] cmd_addr;
    logic [MR_NUM-1:0][ADDR_W-1:0] mode_regs;
    scd_pst_t pstate, pst2;
    logic [NBANK-1:0] bank_open, open2;
    int mismatches = 0;
    int cmp_count = 0;
    scd_link_if lk();
    scd_link_if lk2();
    always #50 clk = ~clk;
    scd_ctl i_scd_ctl (.clk(clk), .rstn(rstn), .req_vld(req_vld), .req_cmd(req_cmd),
        .req_ba(req_ba), .req_addr(req_addr), .req_cke(req_cke), .usr_reset(usr_reset),
        .usr_odt(usr_odt), .req_ack(req_ack), .req_rej(req_rej), .link(lk.ctl));
    scd_dev i_scd_dev (.clk(clk), .rstn(rstn), .link(lk.dev), .cmd_vld(cmd_vld), .cmd(cmd),
        .cmd_ba(cmd_ba), .cmd_addr(cmd_addr), .cmd_ap(cmd_ap), .cmd_chop(cmd_chop),
        .zq_long(zq_long), .mode_regs(mode_regs), .pstate(pstate), .bank_open(bank_open),
        .burst_busy(burst_busy), .dev_idle(dev_idle));
    // second sdram end, its pins driven by the bench to break controller rules
    scd_dev i_scd_dev2 (.clk(clk), .rstn(rstn), .link(lk2.dev), .cmd_vld(), .cmd(),
        .cmd_ba(), .cmd_addr(), .cmd_ap(), .cmd_chop(), .zq_long(), .mode_regs(),
        .pstate(pst2), .bank_open(open2), .burst_busy(), .dev_idle());
    scd_link_assertions i_scd_link_assertions (.clk(clk), .rstn(rstn), .reset_n(lk.reset_n),
        .cke(lk.cke), .cs_n(lk.cs_n), .ras_n(lk.ras_n), .cas_n(lk.cas_n), .we_n(lk.we_n),
        .odt(lk.odt), .ba(lk.ba), .addr(lk.addr));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            mismatches++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, s, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one request pulse; returns once the sdram end has decoded it
    task automatic rq(input scd_cmd_t c, input logic [2:0] b, input logic [15:0] a,
        input logic k);
        @(posedge clk);
        req_vld <= 1'b1;
        req_cmd <= c;
        req_ba <= b;
        req_addr <= a;
        req_cke <= k;
        @(posedge clk);
        req_vld <= 1'b0;
        #1;
        ak = req_ack;
        rj = req_rej;
        cyc(1);
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic t_mrs();
        for (int i = 0; i < MR_NUM; i++)
        begin
            rq(CMD_MRS, 3'(i), 16'h1230 + 16'(i * 4), 1'b1);
            chk(cmd_vld, 1'b1);
            chk(mode_regs[i], 16'h1230 + 16'(i * 4));
        end
    endtask
    task automatic t_cmds();
        scd_cmd_t cl [7] = '{CMD_ZQ, CMD_ZQ, CMD_ACT, CMD_WR, CMD_RD, CMD_PRE, CMD_REF};
        logic [15:0] al [7] = '{16'h0400, 16'h0000, 16'h0055, 16'h1008, 16'h1010,
            16'h0000, 16'h0000};
        @(posedge clk) usr_odt <= 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            rq(cl[i], 3'h1, al[i], 1'b1);
            chk(cmd, cl[i]);
            chk({cmd_ba, cmd_addr}, {3'h1, al[i]});
            chk(bank_open[1], 1'(i > 1 && i < 5));
            if (i < 2)
                chk(zq_long, 1'(i == 0));
        end
        chk(lk.odt, 1'b1);
        rq(CMD_DES, 3'h1, 16'h0000, 1'b1);
        chk(cmd_vld, 1'b0);
        @(posedge clk) usr_odt <= 1'b0;
    endtask
    task automatic t_chop();
        rq(CMD_ACT, 3'h2, 16'h0077, 1'b1);
        rq(CMD_MRS, 3'h0, 16'h0001, 1'b1);
        rq(CMD_RD, 3'h2, 16'h0000, 1'b1);
        chk(cmd_chop, 1'b1);
        rq(CMD_RD, 3'h2, 16'h1000, 1'b1);
        chk(cmd_chop, 1'b0);
        rq(CMD_MRS, 3'h0, 16'h0002, 1'b1);
        rq(CMD_WR, 3'h2, 16'h1000, 1'b1);
        chk(cmd_chop, 1'b1);
        rq(CMD_MRS, 3'h0, 16'h0100, 1'b1);
        rq(CMD_RD, 3'h2, 16'h0400, 1'b1);
        chk({cmd_chop, cmd_ap, bank_open[2]}, 3'b010);
        rq(CMD_RD, 3'h2, 16'h0000, 1'b1);
        chk({ak, rj}, 2'b01);
    endtask
    task automatic t_burst();
        rq(CMD_ACT, 3'h1, 16'h0033, 1'b1);
        rq(CMD_WR, 3'h1, 16'h1000, 1'b1);
        rq(CMD_RD, 3'h1, 16'h1000, 1'b1);
        rq(CMD_RD, 3'h1, 16'h1000, 1'b1);
        cyc(4);
        chk(burst_busy, 1'b1);
        rq(CMD_NOP, 3'h1, 16'h0000, 1'b1);
        chk(cmd_vld, 1'b0);
        rq(CMD_ACT, 3'h1, 16'h0044, 1'b1);
        chk({ak, rj}, 2'b01);
        cyc(12);
        chk(burst_busy, 1'b0);
    endtask
    task automatic t_pd();
        rq(CMD_NOP, 3'h0, 16'h0000, 1'b0);
        chk(pstate, PS_PDA);
        rq(CMD_NOP, 3'h0, 16'h0000, 1'b1);
        chk({ak, rj, pstate}, {2'b01, PS_PDA});
        cyc(3);
        rq(CMD_ACT, 3'h4, 16'h0000, 1'b0);
        chk({ak, bank_open}, 9'h002);
        rq(CMD_NOP, 3'h0, 16'h0000, 1'b1);
        chk(pstate, PS_NORM);
        cyc(3);
        rq(CMD_PRE, 3'h0, 16'h0400, 1'b1);
        chk(bank_open, 8'h00);
        cyc(4);
        rq(CMD_DES, 3'h0, 16'h0000, 1'b0);
        chk(pstate, PS_PDP);
        cyc(3);
        rq(CMD_DES, 3'h0, 16'h0000, 1'b1);
        cyc(8);
        rq(CMD_REF, 3'h0, 16'h0000, 1'b0);
        chk(pstate, PS_SR);
        cyc(3);
        rq(CMD_NOP, 3'h0, 16'h0000, 1'b1);
        chk({pstate, dev_idle}, {PS_NORM, 1'b0});
        cyc(10);
        chk(dev_idle, 1'b1);
        rq(CMD_ACT, 3'h3, 16'h0000, 1'b1);
        rq(CMD_WR, 3'h3, 16'h0400, 1'b1);
        rq(CMD_NOP, 3'h0, 16'h0000, 1'b0);
        chk(pstate, PS_PD);
        cyc(3);
        rq(CMD_NOP, 3'h0, 16'h0000, 1'b1);
    endtask
    // illegal pin sequences straight onto the second sdram end
    task automatic t_bad();
        @(posedge clk) lk2.cke <= 1'b1;
        cyc(4);
        @(posedge clk) {lk2.cke, lk2.cs_n, lk2.ras_n} <= 3'b000;
        cyc(3);
        chk({pst2, open2}, {PS_NORM, 8'h00});
        @(posedge clk) {lk2.cke, lk2.cs_n, lk2.ras_n} <= 3'b111;
        cyc(4);
        @(posedge clk) lk2.cke <= 1'b0;
        cyc(3);
        @(posedge clk) {lk2.cs_n, lk2.ras_n} <= 2'b00;
        cyc(4);
        chk({pst2, open2}, {PS_PDP, 8'h00});
        @(posedge clk) {lk2.cs_n, lk2.ras_n} <= 2'b11;
    endtask
    task automatic t_reset();
        @(posedge clk) usr_reset <= 1'b1;
        cyc(3);
        chk({lk.reset_n, lk.cke, mode_regs[0]}, 18'h00000);
        @(posedge clk) usr_reset <= 1'b0;
        cyc(2);
        rq(CMD_NOP, 3'h0, 16'h0000, 1'b1);
        cyc(4);
        rq(CMD_MRS, 3'h1, 16'h00F0, 1'b1);
        chk(mode_regs[1], 16'h00F0);
        @(posedge clk) rstn <= 1'b0;
        #1 chk(mode_regs[1], 16'h0000);
        @(posedge clk) rstn <= 1'b1;
    endtask
    initial
    begin
        #(4000 * CLK_NS);
        mismatches++;
        finish_test();
    end
    initial
    begin
        {lk2.reset_n, lk2.cke, lk2.cs_n, lk2.ras_n, lk2.cas_n, lk2.we_n} = 6'b101111;
        lk2.odt = 1'b0;
        lk2.ba = 3'h1;
        lk2.addr = 16'h0000;
        repeat (10) @(posedge clk);
        chk({pstate, cmd_vld, bank_open, mode_regs[3]}, 28'h0);
        rstn <= 1'b1;
        rq(CMD_NOP, 3'h0, 16'h0000, 1'b1);
        cyc(4);
        t_mrs();
        t_cmds();
        t_chop();
        t_burst();
        t_pd();
        t_bad();
        t_reset();
        finish_test();
    end
endmodule // sdram_command_cke_decoder_tb
